// [core/tbb_cfg.svh]
// constants shared by the tri-bus data buffer and its controller
`ifndef TBB_CFG_SVH
`define TBB_CFG_SVH

`define TBB_QW_W 64
`define TBB_DW_W 32
`define TBB_BYTE_W 8
`define TBB_PAR_W 8
`define TBB_HM_DEPTH 4
`define TBB_HM_PW 2
`define TBB_HM_CW 3
`define TBB_HM_FULL 3'h4
`define TBB_HP_ENTRIES 4
`define TBB_HP_DW_PER 4
`define TBB_HP_CW 5
`define TBB_HP_LIMIT 5'h10
`define TBB_FIFO_DEPTH 32

`endif

// [core/tbb_pkg.sv]
// types of the tri-bus data buffer and its controller
package tbb_pkg;
`include "tbb_cfg.svh"

    // commands taken by the controller end
    typedef enum logic [3:0] {
        CMD_MEM_PUSH, CMD_MEM_POP, CMD_MEM_RD, CMD_PCI_WR, CMD_PCI_IOWR, CMD_PCI_POP,
        CMD_PCI_RD, CMD_PCI_MWR, CMD_PCI_MWR_L2, CMD_PCI_MRD, CMD_SNOOP_FWD
    } tbb_cmd_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_SETTLE, ST_DRAIN, ST_LAT_LO, ST_LAT_HI, ST_GAP, ST_DW1, ST_FINISH
    } tbb_state_t;

    typedef struct packed {
        logic [`TBB_HM_DEPTH-1:0][`TBB_QW_W-1:0] hm_mem;
        logic [`TBB_HM_PW-1:0] hm_wr;
        logic [`TBB_HM_PW-1:0] hm_rd;
        logic [`TBB_HM_CW-1:0] hm_cnt;
        logic hm_full;
        logic hm_empty;
        logic [`TBB_HP_CW-1:0] hp_cnt;
        logic hp_full;
        logic hp_empty;
        logic [`TBB_QW_W-1:0] pm_buf;
        logic [`TBB_QW_W-1:0] mh_buf;
        logic [`TBB_QW_W-1:0] mp_buf;
        logic par_err;
        logic [`TBB_QW_W-1:0] host_out;
        logic host_oe;
        logic [`TBB_QW_W-1:0] mem_out;
        logic [`TBB_PAR_W-1:0] mem_par;
        logic mem_oe;
        logic [`TBB_DW_W-1:0] pci_out;
        logic pci_oe;
    } tbb_buf_state_t;

    typedef struct packed {
        tbb_state_t state;
        tbb_cmd_t cmd;
        logic tick;
        logic half;
        logic hm_push;
        logic hm_pop;
        logic hp_push;
        logic hp_pop;
        logic hp_fwd;
        logic pm_lat;
        logic pm_to_mem;
        logic pm_to_host;
        logic mh_lat;
        logic mh_drv;
        logic mp_lat;
        logic mp_drv;
        logic ready;
        logic done;
        logic par_err;
    } tbb_ctl_state_t;
endpackage

// [core/tbb_link_if.sv]
// strobe and status link between the controller and the data buffer
`timescale 1ns/100ps
`default_nettype none
interface tbb_link_if;
    logic tick;       // half-rate pci phase, high on pci edges
    logic half;       // doubleword select for split transfers
    logic hm_push;
    logic hm_pop;
    logic hp_push;
    logic hp_pop;
    logic hp_fwd;
    logic pm_lat;
    logic pm_to_mem;
    logic pm_to_host;
    logic mh_lat;
    logic mh_drv;
    logic mp_lat;
    logic mp_drv;
    logic hm_full;
    logic hm_empty;
    logic hp_full;
    logic hp_empty;
    logic par_err;

    modport ctl (
        output tick, half, hm_push, hm_pop, hp_push, hp_pop, hp_fwd, pm_lat, pm_to_mem,
        output pm_to_host, mh_lat, mh_drv, mp_lat, mp_drv,
        input hm_full, hm_empty, hp_full, hp_empty, par_err
    );
    modport dbuf (
        input tick, half, hm_push, hm_pop, hp_push, hp_pop, hp_fwd, pm_lat, pm_to_mem,
        input pm_to_host, mh_lat, mh_drv, mp_lat, mp_drv,
        output hm_full, hm_empty, hp_full, hp_empty, par_err
    );
endinterface
`default_nettype wire

// [core/tbb_fifo.sv]
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
`include "tbb_cfg.svh"
module tbb_fifo
    import tbb_pkg::*;
#(
    parameter int W = `TBB_DW_W,
    parameter int D = `TBB_FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [W-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [W-1:0] o_data
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D + 1);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [CW-1:0] cnt;
    } tbb_fifo_state_t;

    tbb_fifo_state_t r;
    tbb_fifo_state_t next_r;
    logic push;
    logic pop;

    assign o_ready = r.cnt != CW'(D);
    assign o_valid = r.cnt != '0;
    assign o_data = r.mem[r.rd];
    assign push = i_valid && o_ready;
    assign pop = i_ready && o_valid;

    // pointers wrap at the depth, so any depth works, not only powers of two
    always_comb begin
        next_r = r;
        if (push) begin
            next_r.mem[r.wr] = i_data;
            next_r.wr = (r.wr == AW'(D - 1)) ? '0 : r.wr + 1'h1;
        end
        if (pop) begin
            next_r.rd = (r.rd == AW'(D - 1)) ? '0 : r.rd + 1'h1;
        end
        next_r.cnt = r.cnt + CW'(push) - CW'(pop); // [R23]
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
endmodule
`default_nettype wire

// [core/tbb_data_buffer.sv]
// data buffer end: host, memory and pci data paths under controller strobes
// ------------------------------
// Overview of operation
// R1 - host-to-memory write buffer holds four quadwords
// R2 - host-to-pci buffer: four entries of four doublewords
// R3 - pci-to-memory buffer holds one quadword
// R4 - memory-to-host read buffer holds one quadword
// R5 - memory-to-pci read buffer holds one quadword
// R6 - join 64-bit host, 64-bit memory, 32-bit pci
// R7 - run in step with host and half-rate pci
// R8 - host data to memory always passes write buffer
// R9 - latch memory read data before driving host
// R10 - check parity of memory data read for host
// R11 - post host writes to pci, drain when free
// R12 - hold off host pci writes while buffer full
// R13 - io writes use buffer but complete after drain
// R14 - snoop hit data forwarded from host to pci
// R15 - one wait state before second pci doubleword
// R16 - host pci read waits for empty buffer
// R17 - assemble pci read doublewords before host drive
// R18 - pci writes post, go to memory, host too
// R19 - generate parity on every memory write
// R20 - ignore parity on memory-to-pci reads
// R21 - every transfer happens only on controller strobes
// R22 - push on host timing, pop on pci timing
// R23 - push and pop together keep occupancy steady
// ------------------------------
`timescale 1ns/100ps
`default_nettype none
`include "tbb_cfg.svh"
module tbb_data_buffer
    import tbb_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    tbb_link_if.dbuf lk,
    input wire logic [`TBB_QW_W-1:0] i_host_data,
    output logic [`TBB_QW_W-1:0] o_host_data,
    output logic o_host_oe,
    input wire logic [`TBB_QW_W-1:0] i_mem_data,
    input wire logic [`TBB_PAR_W-1:0] i_mem_par,
    output logic [`TBB_QW_W-1:0] o_mem_data,
    output logic [`TBB_PAR_W-1:0] o_mem_par,
    output logic o_mem_oe,
    input wire logic [`TBB_DW_W-1:0] i_pci_ad,
    output logic [`TBB_DW_W-1:0] o_pci_ad,
    output logic o_pci_oe
);
    // ------------------------------
    // state and wires
    // ------------------------------
    tbb_buf_state_t r;
    tbb_buf_state_t next_r;
    logic [`TBB_PAR_W-1:0] par_hm;
    logic [`TBB_PAR_W-1:0] par_pm;
    logic [`TBB_PAR_W-1:0] par_md;
    logic [`TBB_DW_W-1:0] host_dw;
    logic [`TBB_DW_W-1:0] hp_head;
    logic hp_in_ready;
    logic hp_out_valid;
    logic hm_push_ok;
    logic hm_pop_ok;
    logic hp_push_ok;
    logic hp_pop_ok;
    logic pci_edge;

    // all buses share the one clock, so pins are sampled directly without synchronisers
    assign pci_edge = lk.tick; // [R7]
    assign host_dw = lk.half ? i_host_data[`TBB_QW_W-1:`TBB_DW_W] : i_host_data[`TBB_DW_W-1:0];

    // ------------------------------
    // even parity per byte lane
    // ------------------------------
    genvar g;
    generate
        for (g = 0; g < `TBB_PAR_W; g++) begin : g_par
            assign par_hm[g] = ^r.hm_mem[r.hm_rd][g*`TBB_BYTE_W +: `TBB_BYTE_W]; // [R19]
            assign par_pm[g] = ^r.pm_buf[g*`TBB_BYTE_W +: `TBB_BYTE_W]; // [R19]
            assign par_md[g] = ^i_mem_data[g*`TBB_BYTE_W +: `TBB_BYTE_W]; // [R10]
        end
    endgenerate

    // ------------------------------
    // host-to-pci posted write buffer
    // ------------------------------
    // the fifo is deeper than the documented buffer; the occupancy limit
    // below keeps it to four entries of four doublewords
    tbb_fifo #(
        .W(`TBB_DW_W),
        .D(`TBB_FIFO_DEPTH)
    ) u_hp_fifo (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_valid(hp_push_ok),
        .o_ready(hp_in_ready),
        .i_data(host_dw),
        .o_valid(hp_out_valid),
        .i_ready(hp_pop_ok),
        .o_data(hp_head)
    );

    // strobe qualification: nothing moves without a controller strobe
    assign hm_push_ok = lk.hm_push && !r.hm_full; // [R21] [R8]
    assign hm_pop_ok = lk.hm_pop && !r.hm_empty; // [R21]
    assign hp_push_ok = lk.hp_push && !r.hp_full && hp_in_ready; // [R12] [R22]
    assign hp_pop_ok = lk.hp_pop && pci_edge && hp_out_valid; // [R22] [R11]

    // ------------------------------
    // next-state logic
    // ------------------------------
    always_comb begin
        next_r = r;
        next_r.host_oe = 1'h0;
        next_r.mem_oe = 1'h0;
        next_r.pci_oe = 1'h0;

        // host writes and dirty write-backs queue here before memory
        if (hm_push_ok) begin
            next_r.hm_mem[r.hm_wr] = i_host_data; // [R1] [R8]
            next_r.hm_wr = r.hm_wr + 1'h1;
        end
        if (hm_pop_ok) begin
            next_r.hm_rd = r.hm_rd + 1'h1;
        end
        next_r.hm_cnt = r.hm_cnt + `TBB_HM_CW'(hm_push_ok) - `TBB_HM_CW'(hm_pop_ok); // [R23]
        next_r.hm_full = next_r.hm_cnt == `TBB_HM_FULL; // [R1]
        next_r.hm_empty = next_r.hm_cnt == '0;

        // host-to-pci occupancy; a same-cycle push and pop cancel
        next_r.hp_cnt = r.hp_cnt + `TBB_HP_CW'(hp_push_ok) - `TBB_HP_CW'(hp_pop_ok); // [R23]
        next_r.hp_full = next_r.hp_cnt == `TBB_HP_LIMIT; // [R2] [R12]
        next_r.hp_empty = next_r.hp_cnt == '0; // [R16]

        // memory drive: host write data first, pci write data after
        if (hm_pop_ok) begin
            next_r.mem_out = r.hm_mem[r.hm_rd];
            next_r.mem_par = par_hm; // [R19]
            next_r.mem_oe = 1'h1;
        end else if (lk.pm_to_mem) begin
            next_r.mem_out = r.pm_buf; // [R18]
            next_r.mem_par = par_pm; // [R19]
            next_r.mem_oe = 1'h1;
        end

        // pci drive: posted data, then memory read data, then snoop data
        if (hp_pop_ok) begin
            next_r.pci_out = hp_head; // [R11] [R13]
            next_r.pci_oe = 1'h1;
        end else if (lk.mp_drv && pci_edge) begin
            if (lk.half) begin
                next_r.pci_out = r.mp_buf[`TBB_QW_W-1:`TBB_DW_W]; // [R5]
            end else begin
                next_r.pci_out = r.mp_buf[`TBB_DW_W-1:0];
            end
            next_r.pci_oe = 1'h1;
        end else if (lk.hp_fwd && pci_edge) begin
            next_r.pci_out = host_dw; // [R14]
            next_r.pci_oe = 1'h1;
        end

        // pci doublewords assemble into one quadword by half select
        if (lk.pm_lat && pci_edge) begin
            if (lk.half) begin
                next_r.pm_buf[`TBB_QW_W-1:`TBB_DW_W] = i_pci_ad; // [R17] [R3]
            end else begin
                next_r.pm_buf[`TBB_DW_W-1:0] = i_pci_ad; // [R17] [R18]
            end
        end

        // host read of memory: latch and check; flag follows the last latch
        if (lk.mh_lat) begin
            next_r.mh_buf = i_mem_data; // [R4] [R9]
            next_r.par_err = par_md != i_mem_par; // [R10]
        end

        // pci read of memory: parity pins are not looked at here
        if (lk.mp_lat) begin
            next_r.mp_buf = i_mem_data; // [R5] [R20]
        end

        // host drive: held read data first, assembled pci data after
        if (lk.mh_drv) begin
            next_r.host_out = r.mh_buf; // [R9]
            next_r.host_oe = 1'h1;
        end else if (lk.pm_to_host) begin
            next_r.host_out = r.pm_buf; // [R17] [R18]
            next_r.host_oe = 1'h1;
        end
    end

    // ------------------------------
    // registers
    // ------------------------------
    // reset leaves both write buffers reported empty
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            r <= '0;
            r.hm_empty <= 1'h1;
            r.hp_empty <= 1'h1;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------
    // outputs, all straight from flops
    // ------------------------------
    assign o_host_data = r.host_out; // [R6]
    assign o_host_oe = r.host_oe;
    assign o_mem_data = r.mem_out; // [R6]
    assign o_mem_par = r.mem_par;
    assign o_mem_oe = r.mem_oe;
    assign o_pci_ad = r.pci_out; // [R6]
    assign o_pci_oe = r.pci_oe;
    assign lk.hm_full = r.hm_full;
    assign lk.hm_empty = r.hm_empty;
    assign lk.hp_full = r.hp_full;
    assign lk.hp_empty = r.hp_empty;
    assign lk.par_err = r.par_err;
endmodule
`default_nettype wire

// [core/tbb_controller.sv]
// controller end: turns commands into buffer strobes and paces pci steps
`timescale 1ns/100ps
`default_nettype none
module tbb_controller
    import tbb_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    tbb_link_if.ctl lk,
    input wire logic i_cmd_valid,
    input wire tbb_cmd_t i_cmd,
    input wire logic i_half,
    output logic o_cmd_ready,
    output logic o_done,
    output logic o_par_err
);
    // ------------------------------
    // state
    // ------------------------------
    tbb_ctl_state_t r;
    tbb_ctl_state_t next_r;
    logic pci_next;

    // strobes on the pci side must land in a cycle with the tick high
    assign pci_next = !r.tick; // [R22]

    // ------------------------------
    // sequencer
    // ------------------------------
    // each step ends in a finish cycle, so the next command sees fresh status
    always_comb begin
        next_r = r;
        next_r.tick = !r.tick; // [R7]
        {next_r.hm_push, next_r.hm_pop, next_r.hp_push, next_r.hp_pop} = '0;
        {next_r.hp_fwd, next_r.pm_lat, next_r.pm_to_mem, next_r.pm_to_host} = '0;
        {next_r.mh_lat, next_r.mh_drv, next_r.mp_lat, next_r.mp_drv} = '0;
        next_r.done = 1'h0;
        next_r.par_err = lk.par_err;
        case (r.state)
            ST_IDLE: begin
                if (i_cmd_valid) begin
                    next_r.cmd = i_cmd;
                    next_r.half = i_half;
                    case (i_cmd)
                        CMD_MEM_PUSH: if (!lk.hm_full) begin
                            next_r.hm_push = 1'h1; // [R8]
                            next_r.state = ST_FINISH;
                        end
                        CMD_MEM_POP: if (!lk.hm_empty) begin
                            next_r.hm_pop = 1'h1;
                            next_r.state = ST_FINISH;
                        end
                        CMD_MEM_RD: begin
                            next_r.mh_lat = 1'h1; // [R9]
                            next_r.state = ST_DW1;
                        end
                        CMD_PCI_WR: if (!lk.hp_full) begin
                            next_r.hp_push = 1'h1; // [R12] [R11]
                            next_r.state = ST_FINISH;
                        end
                        CMD_PCI_IOWR: if (!lk.hp_full) begin
                            next_r.hp_push = 1'h1; // [R13]
                            next_r.state = ST_SETTLE;
                        end
                        CMD_PCI_POP: if (!lk.hp_empty && pci_next) begin
                            next_r.hp_pop = 1'h1; // [R11]
                            next_r.state = ST_FINISH;
                        end
                        CMD_PCI_RD: next_r.state = ST_DRAIN; // [R16]
                        CMD_PCI_MWR, CMD_PCI_MWR_L2: next_r.state = ST_LAT_LO;
                        CMD_PCI_MRD: begin
                            next_r.mp_lat = 1'h1; // [R20]
                            next_r.state = ST_LAT_LO;
                        end
                        CMD_SNOOP_FWD: if (pci_next) begin
                            next_r.hp_fwd = 1'h1; // [R14]
                            next_r.state = ST_FINISH;
                        end
                        default: next_r.state = ST_IDLE;
                    endcase
                end
            end
            ST_SETTLE: next_r.state = ST_DRAIN; // let the push reach the status
            ST_DRAIN: begin
                // status lags a pop by one cycle, so judge only with no pop in flight
                if (!lk.hp_empty) begin
                    next_r.hp_pop = pci_next; // [R13] [R16]
                end else if (!r.hp_pop) begin
                    next_r.state = (r.cmd == CMD_PCI_IOWR) ? ST_FINISH : ST_LAT_LO;
                end
            end
            ST_LAT_LO: if (pci_next) begin
                next_r.half = 1'h0;
                if (r.cmd == CMD_PCI_MRD) begin
                    next_r.mp_drv = 1'h1;
                    next_r.state = ST_GAP;
                end else begin
                    next_r.pm_lat = 1'h1; // [R17]
                    next_r.state = ST_LAT_HI;
                end
            end
            ST_LAT_HI: if (pci_next) begin
                next_r.half = 1'h1;
                next_r.pm_lat = 1'h1; // [R17]
                next_r.state = ST_DW1;
            end
            ST_GAP: if (pci_next) begin
                next_r.state = ST_DW1; // one idle pci clock between doublewords [R15]
            end
            ST_DW1: begin
                if (r.cmd == CMD_PCI_MRD) begin
                    if (pci_next) begin
                        next_r.half = 1'h1;
                        next_r.mp_drv = 1'h1; // [R15]
                        next_r.state = ST_FINISH;
                    end
                end else begin
                    next_r.mh_drv = r.cmd == CMD_MEM_RD;
                    next_r.pm_to_host = r.cmd == CMD_PCI_RD || r.cmd == CMD_PCI_MWR_L2; // [R18]
                    next_r.pm_to_mem = r.cmd == CMD_PCI_MWR || r.cmd == CMD_PCI_MWR_L2; // [R18]
                    next_r.state = ST_FINISH;
                end
            end
            ST_FINISH: begin
                next_r.done = 1'h1; // [R21]
                next_r.state = ST_IDLE;
            end
            default: next_r.state = ST_IDLE;
        endcase
        next_r.ready = next_r.state == ST_IDLE;
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------
    // outputs
    // ------------------------------
    assign lk.tick = r.tick;
    assign lk.half = r.half;
    assign lk.hm_push = r.hm_push;
    assign lk.hm_pop = r.hm_pop;
    assign lk.hp_push = r.hp_push;
    assign lk.hp_pop = r.hp_pop;
    assign lk.hp_fwd = r.hp_fwd;
    assign lk.pm_lat = r.pm_lat;
    assign lk.pm_to_mem = r.pm_to_mem;
    assign lk.pm_to_host = r.pm_to_host;
    assign lk.mh_lat = r.mh_lat;
    assign lk.mh_drv = r.mh_drv;
    assign lk.mp_lat = r.mp_lat;
    assign lk.mp_drv = r.mp_drv;
    assign o_cmd_ready = r.ready;
    assign o_done = r.done;
    assign o_par_err = r.par_err;
endmodule
`default_nettype wire

// [sim/tbb_link_checker.sv]
// concurrent checks on the strobe link between controller and data buffer
`timescale 1ns/100ps
`default_nettype none
module tbb_link_checker (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic tick,
    input wire logic half,
    input wire logic hm_push,
    input wire logic hm_pop,
    input wire logic hp_push,
    input wire logic hp_pop,
    input wire logic pm_lat,
    input wire logic mh_lat,
    input wire logic mh_drv,
    input wire logic mp_drv,
    input wire logic hm_full,
    input wire logic hm_empty,
    input wire logic hp_full,
    input wire logic hp_empty
);
    // ----------------------------------------
    // occupancy shadows
    // ----------------------------------------
    logic [2:0] hm_n;
    logic [4:0] hp_n;
    // count only strobes the buffer may take, refused ones must change nothing
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            hm_n <= 3'h0;
            hp_n <= 5'h00;
        end else begin
            hm_n <= hm_n + 3'(hm_push && !hm_full) - 3'(hm_pop && !hm_empty);
            hp_n <= hp_n + 5'(hp_push && !hp_full) - 5'(hp_pop && tick && !hp_empty);
        end
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);
    // low doubleword, one skipped pci tick, then the high one
    sequence dw_gap;
        !mp_drv [*3] ##1 (mp_drv && half);
    endsequence
    sequence hi_latch;
        ##2 (pm_lat && half);
    endsequence
    chk_hm_depth_flags: assert property (hm_full == (hm_n == 3'h4) && hm_empty == (hm_n == 3'h0))
        else $error("host-to-memory flags disagree with occupancy");
    chk_hp_depth_flags: assert property (hp_full == (hp_n == 5'h10) && hp_empty == (hp_n == 5'h00))
        else $error("host-to-pci flags disagree with occupancy");
    chk_full_hold_off: assert property (hp_push |-> !hp_full)
        else $error("push issued while host-to-pci buffer full");
    chk_pci_side_tick: assert property (hp_pop || pm_lat || mp_drv |-> tick)
        else $error("pci side strobe outside a pci edge cycle");
    chk_tick_phase: assert property (!$past(i_reset) |-> tick != $past(tick))
        else $error("pci phase did not alternate");
    chk_latch_then_drive: assert property (mh_lat |=> mh_drv)
        else $error("memory read not driven after latch");
    chk_pci_wait_state: assert property (mp_drv && !half |=> dw_gap)
        else $error("second doubleword spacing wrong");
    chk_read_assembly: assert property (pm_lat && !half |-> hi_latch)
        else $error("high doubleword not latched next pci edge");
endmodule
`default_nettype wire

// [sim/tb.sv]
// testbench: controller and data buffer joined over the strobe link
`timescale 1ns/100ps
`default_nettype none
module tb;
    import tbb_pkg::*;
    logic i_clk = 1'b0, i_reset = 1'b1, i_cmd_valid = 1'b0, i_half = 1'b0;
    logic o_cmd_ready, o_done, o_par_err, o_host_oe, o_mem_oe, o_pci_oe;
    tbb_cmd_t i_cmd = CMD_MEM_PUSH;
    logic [63:0] i_host_data = '0, i_mem_data = '0, o_host_data, o_mem_data;
    logic [7:0] i_mem_par = '0, o_mem_par;
    logic [31:0] i_pci_ad, o_pci_ad, pci_lo = '0, pci_hi = '0;
    logic [71:0] mem_q[$], host_q[$], pci_q[$];
    int errors = 0, samples_checked = 0;
    tbb_link_if lk();
    tbb_controller i_tbb_controller(.i_clk(i_clk), .i_reset(i_reset), .lk(lk), .i_cmd_valid(i_cmd_valid),
        .i_cmd(i_cmd), .i_half(i_half), .o_cmd_ready(o_cmd_ready), .o_done(o_done), .o_par_err(o_par_err));
    tbb_data_buffer i_tbb_data_buffer(.i_clk(i_clk), .i_reset(i_reset), .lk(lk), .i_host_data(i_host_data),
        .o_host_data(o_host_data), .o_host_oe(o_host_oe), .i_mem_data(i_mem_data), .i_mem_par(i_mem_par),
        .o_mem_data(o_mem_data), .o_mem_par(o_mem_par), .o_mem_oe(o_mem_oe), .i_pci_ad(i_pci_ad),
        .o_pci_ad(o_pci_ad), .o_pci_oe(o_pci_oe));
    tbb_link_checker i_tbb_link_checker(.i_clk(i_clk), .i_reset(i_reset), .tick(lk.tick), .half(lk.half),
        .hm_push(lk.hm_push), .hm_pop(lk.hm_pop), .hp_push(lk.hp_push), .hp_pop(lk.hp_pop),
        .pm_lat(lk.pm_lat), .mh_lat(lk.mh_lat), .mh_drv(lk.mh_drv), .mp_drv(lk.mp_drv),
        .hm_full(lk.hm_full), .hm_empty(lk.hm_empty), .hp_full(lk.hp_full), .hp_empty(lk.hp_empty));
    // pci target answers whichever doubleword the link selects
    assign i_pci_ad = lk.half ? pci_hi : pci_lo;
    initial forever #2.5 i_clk = ~i_clk;
    // log every driven word, the enables last one cycle only
    always @(posedge i_clk) begin
        if (o_mem_oe === 1'b1) mem_q.push_back({o_mem_par, o_mem_data});
        if (o_host_oe === 1'b1) host_q.push_back({8'h00, o_host_data});
        if (o_pci_oe === 1'b1) pci_q.push_back({40'h00, o_pci_ad});
    end
    function automatic logic [63:0] pat(input int i);
        pat = 64'h0f1e_2d3c_4b5a_6978 * 64'(i + 1);
    endfunction
    function automatic logic [7:0] par8(input logic [63:0] d);
        for (int g = 0; g < 8; g++) par8[g] = ^d[g*8 +: 8];
    endfunction
    task automatic cmp(input string what, input logic [71:0] exp, input logic [71:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp_q(input string what, ref logic [71:0] q[$], input logic [71:0] exp);
        cmp(what, exp, q.size() > 0 ? q.pop_front() : 72'hx);
    endtask
    // one command; a held-off one is withdrawn after twelve cycles
    task automatic run(input tbb_cmd_t c, input logic h, input logic [63:0] d, output logic ok);
        int n;
        @(posedge i_clk);
        i_cmd_valid <= 1'b1;
        i_cmd <= c;
        i_half <= h;
        i_host_data <= d;
        ok = 1'b0;
        for (n = 0; n < 12 && !ok; n++) begin
            @(posedge i_clk);
            #1 ok = !o_cmd_ready;
        end
        @(posedge i_clk);
        i_cmd_valid <= 1'b0;
        #1; // a short command's done pulse already stands here
        for (n = 0; ok && o_done !== 1'b1 && n < 300; n++) begin
            @(posedge i_clk);
            #1;
        end
        if (ok) cmp("command done", 1'b1, o_done);
        repeat (2) @(posedge i_clk);
        #1;
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // watchdog: the whole sequence needs well under ten thousand cycles
    initial begin
        #200000;
        errors++;
        give_verdict();
    end
    initial begin
        logic ok;
        logic [63:0] d;
        repeat (3) @(posedge i_clk);
        i_reset <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            run(CMD_MEM_PUSH, 1'b0, pat(i), ok);
            cmp("memory push taken", i < 4, ok);
        end
        for (int i = 0; i < 4; i++) begin
            run(CMD_MEM_POP, 1'b0, '0, ok);
            cmp_q("memory word", mem_q, {par8(pat(i)), pat(i)});
        end
        // bad parity first, then good: the flag follows the last read
        for (int i = 0; i < 2; i++) begin
            i_mem_data <= pat(i + 7);
            i_mem_par <= par8(pat(i + 7)) ^ {5'h00, i == 0, 2'h0};
            run(CMD_MEM_RD, 1'b0, '0, ok);
            cmp_q("host word", host_q, pat(i + 7));
            cmp("parity flag", i == 0, o_par_err);
        end
        for (int i = 0; i < 17; i++) begin
            run(CMD_PCI_WR, i[0], pat(i), ok);
            cmp("pci push taken", i < 16, ok);
        end
        for (int i = 0; i < 16; i++) begin
            run(CMD_PCI_POP, 1'b0, '0, ok);
            d = pat(i);
            cmp_q("pci word", pci_q, i[0] ? d[63:32] : d[31:0]);
        end
        d = pat(20);
        run(CMD_PCI_IOWR, 1'b1, d, ok);
        cmp("io write drained", 1'b1, lk.hp_empty);
        cmp_q("io word", pci_q, d[63:32]);
        d = pat(21);
        run(CMD_PCI_WR, 1'b0, d, ok);
        pci_lo <= 32'h89ab_cdef;
        pci_hi <= 32'h0246_8ace;
        run(CMD_PCI_RD, 1'b0, '0, ok);
        cmp_q("drained before read", pci_q, d[31:0]);
        cmp_q("assembled read", host_q, {pci_hi, pci_lo});
        for (int i = 0; i < 2; i++) begin
            run(i ? CMD_PCI_MWR_L2 : CMD_PCI_MWR, 1'b0, '0, ok);
            cmp_q("pci write to memory", mem_q, {par8({pci_hi, pci_lo}), pci_hi, pci_lo});
            cmp("pci write to host count", i, host_q.size());
            if (i) cmp_q("pci write to host", host_q, {pci_hi, pci_lo});
        end
        d = pat(30);
        i_mem_data <= d;
        i_mem_par <= ~par8(d);
        run(CMD_PCI_MRD, 1'b0, '0, ok);
        cmp_q("memory read low", pci_q, d[31:0]);
        cmp_q("memory read high", pci_q, d[63:32]);
        cmp("no flag on pci read", 1'b0, o_par_err);
        d = pat(31);
        run(CMD_SNOOP_FWD, 1'b1, d, ok);
        cmp_q("snoop forward", pci_q, d[63:32]);
        cmp("stray words", 0, mem_q.size() + host_q.size() + pci_q.size());
        give_verdict();
    end
endmodule
`default_nettype wire
